//--- verilog/asb_aux_master.sv
// Auxiliary two-wire bus master with pass-through switch and sample FIFO
module asb_aux_master (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic masterEn,
	input wire logic bypassReq,
	input wire logic sampleTick,
	input wire asb_pkg::asb_chan_cfg_arr_t chanCfg,
	input wire logic spiMode,
	input wire logic addressSelectPin,
	input wire logic auxSerialClockIn,
	output logic auxSerialClockOut,
	output logic auxSerialClockOeN,
	input wire logic auxSerialDataIn,
	output logic auxSerialDataOut,
	output logic auxSerialDataOeN,
	output logic bypassSwitchOn,
	output logic [6:0] slaveAddr,
	output asb_pkg::asb_ext_data_t extSensorData,
	output logic [4:0] extByteCount,
	output logic [7:0] slv4Data,
	output logic slv4Done,
	output logic nackIrq,
	output logic arbLostIrq,
	output logic roundDone,
	input wire logic fifoRdReq,
	output logic [7:0] fifoRdData,
	output logic fifoRdValid,
	output logic [10:0] fifoCount
);
	import asb_pkg::*;

	logic [1:0] rstSync;
	logic rstN;
	asb_core_t r;
	asb_core_t n;
	asb_chan_cfg_t cfg;
	logic go;
	logic sclHigh;
	logic sdaIn;
	logic bufInReady;
	logic bufOutValid;
	logic [7:0] bufOutData;
	logic bufOutReady;
	logic memWe;
	logic memRe;
	logic [7:0] fifoMem [0:FIFO_DEPTH-1];

	assign rstN = rstSync[1];
	assign cfg = (r.ch < CH_END) ? chanCfg[r.ch] : '0;
	assign go = (r.div == 5'h00);
	assign sclHigh = r.sync2[SY_SCL];
	assign sdaIn = r.sync2[SY_SDA];
	// Full store stalls the buffer, which in turn stretches the bus clock
	assign bufOutReady = (r.fifoCnt != FIFO_FULL);
	assign memWe = bufOutValid && bufOutReady;
	assign memRe = fifoRdReq && (r.fifoCnt != 11'h000);

	assign auxSerialClockOut = r.pinLow;
	assign auxSerialDataOut = r.pinLow;
	assign auxSerialClockOeN = r.sclOeN;
	assign auxSerialDataOeN = r.sdaOeN;
	assign bypassSwitchOn = r.bypass;
	assign slaveAddr = r.slaveAddr;
	assign extSensorData = r.extData;
	assign extByteCount = r.ptr;
	assign slv4Data = r.slv4Data;
	assign slv4Done = r.slv4Done;
	assign nackIrq = r.nackIrq;
	assign arbLostIrq = r.arbIrq;
	assign roundDone = r.roundDone;
	assign fifoRdData = r.rdData;
	assign fifoRdValid = r.rdValid;
	assign fifoCount = r.fifoCnt;

	asb_skid_buf u_buf (
		.core_clk(core_clk),
		.rstN(rstN),
		.inValid(r.pushV),
		.inData(r.pushD),
		.inReady(bufInReady),
		.outValid(bufOutValid),
		.outData(bufOutData),
		.outReady(bufOutReady)
	);

	always_comb begin
		n = r;
		n.sync1 = {auxSerialClockIn, auxSerialDataIn, spiMode, addressSelectPin};
		n.sync2 = r.sync1;
		n.slaveAddr = {SLAVE_ADDR_HI, r.sync2[SY_ADS]};
		// Shared serial pins in SPI mode leave no path to the sensor bus
		n.bypass = bypassReq && !r.sync2[SY_SPI];
		n.nackIrq = 1'b0;
		n.arbIrq = 1'b0;
		n.slv4Done = 1'b0;
		n.roundDone = 1'b0;
		n.pushV = 1'b0;
		n.rdValid = 1'b0;
		if (!go) begin
			n.div = r.div - 5'h01;
		end
		case (r.st)
			ST_IDLE: begin
				n.sclOeN = 1'b1;
				n.sdaOeN = 1'b1;
				if (masterEn && !r.bypass && sampleTick) begin
					n.st = ST_PICK;
					n.ch = 3'h0;
					n.ptr = 5'h00;
				end
			end
			ST_PICK: begin
				if (r.ch == CH_END) begin
					n.st = ST_IDLE;
					n.roundDone = 1'b1;
				end else if (!cfg.en) begin
					n.ch = r.ch + 3'h1;
				end else begin
					n.rdOp = cfg.rd;
					n.toFifo = cfg.toFifo && (r.ch != SLV4_IDX);
					n.left = (r.ch == SLV4_IDX) ? 5'h01 : clampLen(cfg.len, r.ptr);
					if (cfg.rd && n.left == 5'h00) begin
						n.ch = r.ch + 3'h1;
					end else begin
						n.st = ST_START;
						n.step = STEP_ADDRW;
						n.ph = 2'h0;
						n.div = QTR_RELOAD;
					end
				end
			end
			ST_START: begin
				if (go) begin
					n.div = QTR_RELOAD;
					n.ph = r.ph + 2'h1;
					case (r.ph)
						2'h0: begin
							n.sclOeN = 1'b1;
							n.sdaOeN = 1'b1;
						end
						2'h1: begin
							if (sclHigh) begin
								n.sdaOeN = 1'b0;
							end else begin
								n.div = r.div;
								n.ph = r.ph;
							end
						end
						2'h2: n.sclOeN = 1'b0;
						default: begin
							n.st = ST_TX;
							n.bitCnt = 4'h0;
							n.shift = {cfg.devAddr, 1'b0};
						end
					endcase
				end
			end
			ST_RSTART: begin
				if (go) begin
					n.div = QTR_RELOAD;
					n.ph = r.ph + 2'h1;
					case (r.ph)
						2'h0: begin
							n.sclOeN = 1'b0;
							n.sdaOeN = 1'b1;
						end
						2'h1: begin
							n.sclOeN = 1'b1;
							if (!sclHigh) begin
								n.div = r.div;
								n.ph = r.ph;
							end
						end
						2'h2: n.sdaOeN = 1'b0;
						default: begin
							n.sclOeN = 1'b0;
							n.st = ST_TX;
							n.step = STEP_ADDRR;
							n.bitCnt = 4'h0;
							n.shift = {cfg.devAddr, 1'b1};
						end
					endcase
				end
			end
			ST_TX: begin
				if (go) begin
					n.div = QTR_RELOAD;
					n.ph = r.ph + 2'h1;
					case (r.ph)
						2'h0: begin
							n.sclOeN = 1'b0;
							n.sdaOeN = (r.bitCnt == ACK_BIT) ? 1'b1 : r.shift[7];
						end
						2'h1: begin
							// Waiting here honours clock stretching by the sensor
							n.sclOeN = 1'b1;
							if (!sclHigh) begin
								n.div = r.div;
								n.ph = r.ph;
							end
						end
						2'h2: begin
							if (r.bitCnt != ACK_BIT && r.shift[7] && !sdaIn) begin
								n.arbIrq = 1'b1;
								n.st = ST_IDLE;
								n.sclOeN = 1'b1;
								n.sdaOeN = 1'b1;
							end else if (r.bitCnt == ACK_BIT && sdaIn) begin
								n.nackIrq = 1'b1;
								n.st = ST_STOP;
								n.ph = 2'h0;
								n.sclOeN = 1'b0;
							end
						end
						default: begin
							n.sclOeN = 1'b0;
							if (r.bitCnt != ACK_BIT) begin
								n.bitCnt = r.bitCnt + 4'h1;
								n.shift = {r.shift[6:0], 1'b0};
							end else begin
								n.bitCnt = 4'h0;
								case (r.step)
									STEP_ADDRW: begin
										n.step = STEP_REG;
										n.shift = cfg.regAddr;
									end
									STEP_REG: begin
										if (r.rdOp) begin
											n.st = ST_RSTART;
										end else begin
											n.step = STEP_WDATA;
											n.shift = cfg.wdata;
										end
									end
									STEP_WDATA: begin
										n.st = ST_STOP;
										n.slv4Done = (r.ch == SLV4_IDX);
									end
									default: n.st = ST_RX;
								endcase
							end
						end
					endcase
				end
			end
			ST_RX: begin
				if (go) begin
					n.div = QTR_RELOAD;
					n.ph = r.ph + 2'h1;
					case (r.ph)
						2'h0: begin
							n.sclOeN = 1'b0;
							n.sdaOeN = 1'b1;
							if (r.bitCnt == ACK_BIT) begin
								if (r.toFifo && !bufInReady) begin
									n.div = r.div;
									n.ph = r.ph;
								end else begin
									n.pushV = r.toFifo;
									n.pushD = r.shift;
									if (r.ch == SLV4_IDX) begin
										n.slv4Data = r.shift;
										n.slv4Done = 1'b1;
									end else if (r.ptr < EXT_BYTES) begin
										n.extData[r.ptr] = r.shift;
										n.ptr = r.ptr + 5'h01;
									end
									// Last byte of a burst is refused so the sensor lets go
									n.sdaOeN = (r.left == 5'h01);
									n.left = r.left - 5'h01;
								end
							end
						end
						2'h1: begin
							n.sclOeN = 1'b1;
							if (!sclHigh) begin
								n.div = r.div;
								n.ph = r.ph;
							end
						end
						2'h2: begin
							if (r.bitCnt != ACK_BIT) begin
								n.shift = {r.shift[6:0], sdaIn};
							end
						end
						default: begin
							n.sclOeN = 1'b0;
							if (r.bitCnt != ACK_BIT) begin
								n.bitCnt = r.bitCnt + 4'h1;
							end else if (r.left == 5'h00) begin
								n.st = ST_STOP;
							end else begin
								n.bitCnt = 4'h0; // Ack held to next quarter: no false stop
							end
						end
					endcase
				end
			end
			ST_STOP: begin
				if (go) begin
					n.div = QTR_RELOAD;
					n.ph = r.ph + 2'h1;
					case (r.ph)
						2'h0: begin
							n.sclOeN = 1'b0;
							n.sdaOeN = 1'b0;
						end
						2'h1: begin
							n.sclOeN = 1'b1;
							if (!sclHigh) begin
								n.div = r.div;
								n.ph = r.ph;
							end
						end
						2'h2: n.sdaOeN = 1'b1;
						default: begin
							n.st = ST_PICK;
							n.ch = r.ch + 3'h1;
						end
					endcase
				end
			end
			default: n.st = ST_IDLE;
		endcase
		// Dropping master mode or entering pass-through cuts any transfer short
		if (!masterEn || r.bypass) begin
			n.st = ST_IDLE;
			n.sclOeN = 1'b1;
			n.sdaOeN = 1'b1;
		end
		if (memWe) begin
			n.wrPtr = r.wrPtr + 10'h001;
		end
		if (memRe) begin
			n.rdData = fifoMem[r.rdPtr];
			n.rdPtr = r.rdPtr + 10'h001;
			n.rdValid = 1'b1;
		end
		n.fifoCnt = r.fifoCnt + {10'h000, memWe} - {10'h000, memRe};
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rstSync <= 2'h0;
		end else begin
			rstSync <= {rstSync[0], 1'b1};
		end
	end

	always_ff @(posedge core_clk or negedge rstN) begin
		if (!rstN) begin
			r <= CORE_RST;
		end else begin
			r <= n;
		end
	end

	// Store array carries no reset; the pointers and count define its contents
	always_ff @(posedge core_clk) begin
		if (memWe) begin
			fifoMem[r.wrPtr] <= bufOutData;
		end
	end
endmodule // asb_aux_master

//--- verilog/asb_pkg.sv
// Shared constants, types and reset values for the auxiliary sensor bus master
package asb_pkg;

	localparam int CLK_PERIOD_NS = 40;
	localparam int SCL_PERIOD_NS = 2500;
	// Least quarter of a 400 kHz bit period, rounded up to whole clocks
	localparam int QTR_CYC = (SCL_PERIOD_NS / 4 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [4:0] QTR_RELOAD = 5'(QTR_CYC - 1);

	localparam logic [4:0] EXT_BYTES = 5'h18;
	localparam logic [2:0] SLV4_IDX = 3'h4;
	localparam logic [2:0] CH_END = 3'h5;
	localparam int FIFO_DEPTH = 1024;
	localparam logic [10:0] FIFO_FULL = 11'h400;
	localparam logic [5:0] SLAVE_ADDR_HI = 6'h34;
	localparam logic [3:0] ACK_BIT = 4'h8;

	// Synchroniser bit positions
	localparam int SY_SCL = 3;
	localparam int SY_SDA = 2;
	localparam int SY_SPI = 1;
	localparam int SY_ADS = 0;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_PICK = 3'b001,
		ST_START = 3'b010,
		ST_TX = 3'b011,
		ST_RX = 3'b100,
		ST_RSTART = 3'b101,
		ST_STOP = 3'b110
	} asb_state_t;

	typedef enum logic [1:0] {
		STEP_ADDRW = 2'b00,
		STEP_REG = 2'b01,
		STEP_WDATA = 2'b10,
		STEP_ADDRR = 2'b11
	} asb_step_t;

	typedef struct packed {
		logic en;
		logic rd;
		logic toFifo;
		logic [6:0] devAddr;
		logic [7:0] regAddr;
		logic [3:0] len;
		logic [7:0] wdata;
	} asb_chan_cfg_t;

	typedef asb_chan_cfg_t [4:0] asb_chan_cfg_arr_t;
	typedef logic [23:0][7:0] asb_ext_data_t;

	typedef struct packed {
		asb_state_t st;
		asb_step_t step;
		logic [2:0] ch;
		logic [1:0] ph;
		logic [4:0] div;
		logic [3:0] bitCnt;
		logic [7:0] shift;
		logic [4:0] left;
		logic [4:0] ptr;
		logic rdOp;
		logic toFifo;
		logic pinLow;
		logic sclOeN;
		logic sdaOeN;
		logic [3:0] sync1;
		logic [3:0] sync2;
		logic bypass;
		logic [6:0] slaveAddr;
		asb_ext_data_t extData;
		logic [7:0] slv4Data;
		logic slv4Done;
		logic nackIrq;
		logic arbIrq;
		logic roundDone;
		logic pushV;
		logic [7:0] pushD;
		logic [10:0] fifoCnt;
		logic [9:0] wrPtr;
		logic [9:0] rdPtr;
		logic [7:0] rdData;
		logic rdValid;
	} asb_core_t;

	localparam asb_core_t CORE_RST = '{
		st: ST_IDLE, step: STEP_ADDRW, ch: 3'h0, ph: 2'h0, div: 5'h00,
		bitCnt: 4'h0, shift: 8'h00, left: 5'h00, ptr: 5'h00,
		rdOp: 1'b0, toFifo: 1'b0, pinLow: 1'b0, sclOeN: 1'b1, sdaOeN: 1'b1,
		sync1: 4'h0, sync2: 4'h0, bypass: 1'b0, slaveAddr: {SLAVE_ADDR_HI, 1'b0},
		extData: '0, slv4Data: 8'h00, slv4Done: 1'b0, nackIrq: 1'b0, arbIrq: 1'b0,
		roundDone: 1'b0, pushV: 1'b0, pushD: 8'h00, fifoCnt: 11'h000,
		wrPtr: 10'h000, rdPtr: 10'h000, rdData: 8'h00, rdValid: 1'b0
	};

	typedef struct packed {
		logic [1:0][7:0] mem;
		logic wp;
		logic rp;
		logic [1:0] cnt;
	} asb_buf_t;

	localparam asb_buf_t BUF_RST = '{mem: '0, wp: 1'b0, rp: 1'b0, cnt: 2'h0};
	localparam logic [1:0] BUF_FULL = 2'h2;

	// Bytes a burst channel may still take before the 24-byte window is used up
	function automatic logic [4:0] clampLen(input logic [3:0] len, input logic [4:0] used);
		logic [4:0] room;
		room = EXT_BYTES - used;
		return ({1'b0, len} > room) ? room : {1'b0, len};
	endfunction

endpackage

//--- verilog/asb_skid_buf.sv
// Two-entry byte buffer between the bus engine and the FIFO store
module asb_skid_buf (
	input wire logic core_clk,
	input wire logic rstN,
	input wire logic inValid,
	input wire logic [7:0] inData,
	output logic inReady,
	output logic outValid,
	output logic [7:0] outData,
	input wire logic outReady
);
	import asb_pkg::*;

	asb_buf_t r;
	asb_buf_t n;
	logic push;
	logic pop;

	assign inReady = (r.cnt != BUF_FULL);
	assign outValid = (r.cnt != 2'h0);
	assign outData = r.mem[r.rp];
	assign push = inValid && inReady;
	assign pop = outValid && outReady;

	always_comb begin
		n = r;
		if (push) begin
			n.mem[r.wp] = inData;
			n.wp = ~r.wp;
		end
		if (pop) begin
			n.rp = ~r.rp;
		end
		n.cnt = r.cnt + {1'b0, push} - {1'b0, pop};
	end

	always_ff @(posedge core_clk or negedge rstN) begin
		if (!rstN) begin
			r <= BUF_RST;
		end else begin
			r <= n;
		end
	end
endmodule // asb_skid_buf

//--- sim/asb_sensor_model.sv
// Behavioural sensor on the auxiliary two-wire bus; register reads return the register index
module asb_sensor_model #(
	parameter logic [6:0] DEV_ADDR = 7'h1c
) (
	input wire logic scl,
	input wire logic sda,
	input wire logic slow,
	output logic sclOeN,
	output logic sdaOeN
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] sh, regP, dat, lastW, lastReg;
	int bitN, byteN, rdN;
	logic act, rd;
	initial begin
		sclOeN = 1'b1;
		sdaOeN = 1'b1;
		act = 1'b0;
		rd = 1'b0;
	end
	always @(negedge sda) if (scl) begin
		act = 1'b1;
		// The clock fall that closes the start brings this to zero
		bitN = -1;
		byteN = 0;
		rd = 1'b0;
		rdN = 0;
	end
	always @(posedge sda) if (scl) begin
		act = 1'b0;
		sdaOeN = 1'b1;
	end
	always @(posedge scl) if (act) begin
		if (bitN < 8)
			sh = {sh[6:0], sda};
		else if (rd && sda)
			act = 1'b0;
	end
	always @(negedge scl) if (act) begin
		bitN = (bitN == 8) ? 0 : bitN + 1;
		sdaOeN = 1'b1;
		if (bitN == 8 && !rd) begin
			if (byteN == 0) begin
				act = (sh[7:1] == DEV_ADDR);
				rd = sh[0];
			end else if (byteN == 1)
				regP = sh;
			else begin
				lastReg = regP;
				lastW = sh;
			end
			byteN++;
			sdaOeN = !act;
			if (slow) begin
				// Stretch the ack slot so the master has to wait
				sclOeN = 1'b0;
				#2000 sclOeN = 1'b1;
			end
		end else if (rd && bitN < 8) begin
			if (bitN == 0) begin
				dat = regP;
				regP++;
				rdN++;
			end
			sdaOeN = dat[7 - bitN];
		end
	end
endmodule // asb_sensor_model

//--- sim/asb_aux_master_sva.sv
// Concurrent checks on the auxiliary bus master ports
module asb_aux_master_chk (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic masterEn,
	input wire logic bypassReq,
	input wire logic spiMode,
	input wire logic addressSelectPin,
	input wire logic fifoRdReq,
	input wire logic auxSerialClockOeN,
	input wire logic auxSerialDataOeN,
	input wire logic bypassSwitchOn,
	input wire logic [6:0] slaveAddr,
	input wire logic [4:0] extByteCount,
	input wire logic nackIrq,
	input wire logic fifoRdValid,
	input wire logic [10:0] fifoCount
);
	timeunit 1ns;
	timeprecision 1ns;
	// Pin-driven outputs lag reset release through synchronisers
	logic [3:0] upCnt;
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n)
			upCnt <= 4'h0;
		else if (upCnt != 4'hf)
			upCnt <= upCnt + 4'h1;
	end
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!reset_n);
	AST_BYP_QUIET: assert property (bypassSwitchOn && $past(bypassSwitchOn) |->
		auxSerialClockOeN && auxSerialDataOeN) else $error("engine drives pins in pass-through");
	AST_BYP_ON: assert property ((upCnt == 4'hf && bypassReq && !spiMode)[*5]
		|-> bypassSwitchOn) else $error("pass-through switch not closed");
	AST_SPI_BLOCK: assert property ((upCnt == 4'hf && spiMode)[*5] |-> !bypassSwitchOn)
		else $error("pass-through closed in serial-peripheral mode");
	AST_ADDR_LSB: assert property ((upCnt == 4'hf && $stable(addressSelectPin))[*5]
		|-> slaveAddr == {6'h34, addressSelectPin}) else $error("slave address wrong");
	AST_EXT_LIMIT: assert property (extByteCount <= 5'h18)
		else $error("sensor byte count above limit");
	AST_FIFO_LIMIT: assert property (fifoCount <= 11'h400)
		else $error("store count above capacity");
	AST_FIFO_READ: assert property (fifoRdReq && fifoCount != 11'h000 |=>
		fifoRdValid && fifoCount <= $past(fifoCount)) else $error("store read not answered");
	AST_FIFO_EMPTY: assert property (fifoRdReq && fifoCount == 11'h000 |=> !fifoRdValid)
		else $error("read of empty store answered");
	AST_NACK_STOP: assert property (nackIrq |-> ##[1:300]
		($rose(auxSerialDataOeN) && auxSerialClockOeN)) else $error("no stop after refusal");
	AST_MASTER_OFF: assert property (!masterEn[*3] |->
		auxSerialClockOeN && auxSerialDataOeN) else $error("pins driven with master off");
endmodule // asb_aux_master_chk

bind asb_aux_master asb_aux_master_chk asb_aux_master_chk_inst (.core_clk, .reset_n, .masterEn,
	.bypassReq, .spiMode, .addressSelectPin, .fifoRdReq, .auxSerialClockOeN, .auxSerialDataOeN,
	.bypassSwitchOn, .slaveAddr, .extByteCount, .nackIrq, .fifoRdValid, .fifoCount);

//--- sim/asb_aux_master_bench.sv
// Self-checking bench for the auxiliary sensor bus master
module asb_aux_master_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import asb_pkg::*;
	logic core_clk = 1'b0;
	logic reset_n = 1'b0;
	logic masterEn = 1'b0, bypassReq = 1'b0, sampleTick = 1'b0, spiMode = 1'b0;
	logic addressSelectPin = 1'b0, fifoRdReq = 1'b0, slow = 1'b0, grab = 1'b0;
	asb_chan_cfg_arr_t chanCfg = '0;
	logic sclOeN, sdaOeN, mSclOeN, mSdaOeN, bypassSwitchOn, slv4Done, nackIrq, roundDone;
	logic fifoRdValid, arbLostIrq, sclOut, sdaOut;
	logic [6:0] slaveAddr;
	asb_ext_data_t extSensorData;
	logic [4:0] extByteCount;
	logic [7:0] slv4Data, fifoRdData;
	logic [10:0] fifoCount;
	// Pull-ups hold released lines high
	wire sclW = sclOeN & mSclOeN;
	// Grab stands for a rival master holding SDA low
	wire sdaW = sdaOeN & mSdaOeN & !grab;
	int error_cnt = 0;
	int checked = 0;
	int nk;
	int ns4;
	asb_aux_master asb_aux_master_inst (.core_clk, .reset_n, .masterEn, .bypassReq, .sampleTick,
		.chanCfg, .spiMode, .addressSelectPin, .auxSerialClockIn(sclW), .auxSerialClockOut(sclOut),
		.auxSerialClockOeN(sclOeN), .auxSerialDataIn(sdaW), .auxSerialDataOut(sdaOut),
		.auxSerialDataOeN(sdaOeN), .bypassSwitchOn, .slaveAddr, .extSensorData, .extByteCount,
		.slv4Data, .slv4Done, .nackIrq, .arbLostIrq, .roundDone, .fifoRdReq, .fifoRdData,
		.fifoRdValid, .fifoCount);
	asb_sensor_model asb_sensor_model_inst (.scl(sclW), .sda(sdaW), .slow,
		.sclOeN(mSclOeN), .sdaOeN(mSdaOeN));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t ns: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic results();
		$display("checked %0d, error_cnt %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	function automatic asb_chan_cfg_t cfg(input logic [6:0] dev, input logic [7:0] ra,
		input logic [3:0] len, input logic rd, input logic toF);
		return '{en: 1'b1, rd: rd, toFifo: toF, devAddr: dev, regAddr: ra, len: len, wdata: 8'ha5};
	endfunction
	task automatic runRound(input asb_chan_cfg_arr_t c);
		int i;
		i = 0;
		nk = 0;
		ns4 = 0;
		@(posedge core_clk) chanCfg <= c;
		@(posedge core_clk) sampleTick <= 1'b1;
		@(posedge core_clk) sampleTick <= 1'b0;
		do begin
			tick(1);
			nk += int'(nackIrq);
			ns4 += int'(slv4Done);
			i++;
		end while (roundDone !== 1'b1 && i < 30000);
		chk(roundDone, 1);
	endtask
	task automatic testReset();
		chk(slaveAddr, 7'h68);
		chk({sclOeN, sdaOeN, bypassSwitchOn}, 3'b110);
		chk({sclOut, sdaOut}, 2'b00);
		@(posedge core_clk) addressSelectPin <= 1'b1;
		tick(6);
		chk(slaveAddr, 7'h69);
	endtask
	task automatic testBurst();
		asb_chan_cfg_arr_t c = '0;
		int k;
		int i;
		c[0] = cfg(7'h1c, 8'h10, 4'h6, 1'b1, 1'b1);
		c[1] = cfg(7'h1c, 8'h40, 4'h1, 1'b0, 1'b0);
		c[4] = cfg(7'h1c, 8'h20, 4'h3, 1'b1, 1'b0);
		@(posedge core_clk) slow <= 1'b1;
		runRound(c);
		chk(nk, 0);
		chk(extByteCount, 5'h06);
		for (k = 0; k < 6; k++)
			chk(extSensorData[k], 8'h10 + k);
		chk({asb_sensor_model_inst.lastReg, asb_sensor_model_inst.lastW}, 16'h40a5);
		chk(slv4Data, 8'h20);
		chk(asb_sensor_model_inst.rdN, 1);
		chk(ns4, 1);
		chk(fifoCount, 11'h006);
		k = 0;
		for (i = 0; i < 10; i++) begin
			@(posedge core_clk);
			fifoRdReq <= (i < 7);
			#1;
			if (fifoRdValid === 1'b1) begin
				chk(fifoRdData, 8'h10 + k);
				k++;
			end
		end
		chk(k, 6);
		chk(fifoCount, 11'h000);
	endtask
	task automatic testClamp();
		asb_chan_cfg_arr_t c = '0;
		c[0] = cfg(7'h1c, 8'h00, 4'hf, 1'b1, 1'b0);
		c[1] = cfg(7'h1c, 8'h80, 4'hf, 1'b1, 1'b0);
		@(posedge core_clk) slow <= 1'b0;
		runRound(c);
		chk(extByteCount, 5'h18);
		chk({extSensorData[14], extSensorData[15], extSensorData[23]}, 24'h0e8088);
		chk(asb_sensor_model_inst.rdN, 9);
		chk(fifoCount, 11'h000);
	endtask
	task automatic testNack();
		asb_chan_cfg_arr_t c = '0;
		c[0] = cfg(7'h2b, 8'h00, 4'h2, 1'b1, 1'b1);
		c[1] = cfg(7'h1c, 8'h30, 4'h1, 1'b1, 1'b1);
		runRound(c);
		chk(nk, 1);
		chk(extByteCount, 5'h01);
		chk(extSensorData[0], 8'h30);
		chk(fifoCount, 11'h001);
	endtask
	task automatic testAbort();
		asb_chan_cfg_arr_t c = '0;
		int i;
		int busy;
		c[0] = cfg(7'h1c, 8'h00, 4'h2, 1'b1, 1'b0);
		@(posedge core_clk) chanCfg <= c;
		grab <= 1'b1;
		@(posedge core_clk) sampleTick <= 1'b1;
		@(posedge core_clk) sampleTick <= 1'b0;
		i = 0;
		do begin
			tick(1);
			i++;
		end while (arbLostIrq !== 1'b1 && i < 2000);
		chk({arbLostIrq, sclOeN, sdaOeN, roundDone}, 4'b1110);
		@(posedge core_clk) grab <= 1'b0;
		@(posedge core_clk) sampleTick <= 1'b1;
		@(posedge core_clk) sampleTick <= 1'b0;
		busy = 0;
		for (i = 0; i < 200; i++) begin
			tick(1);
			busy += int'(!sclOeN);
		end
		chk(busy > 0, 1);
		@(posedge core_clk) masterEn <= 1'b0;
		tick(2);
		chk({sclOeN, sdaOeN}, 2'b11);
		@(posedge core_clk) masterEn <= 1'b1;
	endtask
	task automatic testBypass();
		asb_chan_cfg_arr_t c = '0;
		int i;
		int bad;
		bad = 0;
		@(posedge core_clk) bypassReq <= 1'b1;
		tick(6);
		chk(bypassSwitchOn, 1);
		@(posedge core_clk) sampleTick <= 1'b1;
		@(posedge core_clk) sampleTick <= 1'b0;
		for (i = 0; i < 100; i++) begin
			tick(1);
			if ((sclOeN & sdaOeN & !roundDone) !== 1'b1)
				bad++;
		end
		chk(bad, 0);
		@(posedge core_clk) fifoRdReq <= 1'b1;
		@(posedge core_clk) fifoRdReq <= 1'b0;
		#1;
		chk({fifoRdValid, fifoRdData}, 9'h130);
		@(posedge core_clk) spiMode <= 1'b1;
		tick(6);
		chk(bypassSwitchOn, 0);
		// Host leaves pass-through before the master polls again
		@(posedge core_clk) bypassReq <= 1'b0;
		tick(6);
		chk(bypassSwitchOn, 0);
		c[0] = cfg(7'h1c, 8'h55, 4'h1, 1'b1, 1'b0);
		runRound(c);
		chk({extByteCount, extSensorData[0]}, 13'h0155);
	endtask
	initial begin
		forever #20 core_clk = ~core_clk;
	end
	initial begin
		repeat (20) @(posedge core_clk);
		reset_n <= 1'b1;
		tick(8);
		testReset();
		@(posedge core_clk) masterEn <= 1'b1;
		testBurst();
		testClamp();
		testNack();
		testAbort();
		testBypass();
		results();
	end
	initial begin
		#3000000;
		error_cnt++;
		results();
	end
endmodule // asb_aux_master_bench
